// ===== logic/tsf_consts.svh
// constants for the thermal status flag block
`ifndef TSF_CONSTS_SVH
`define TSF_CONSTS_SVH
`define TSF_NUM_CH            6
`define TSF_ADDR_W            7
`define TSF_SLAVE_ADDR        7'h1A
`define TSF_REG_OVERTEMP      8'h00
`define TSF_REG_DIODE_FAULT   8'h01
`define TSF_REG_CONFIG3       8'h02
`define TSF_OT_VALID_MASK     8'h39
`define TSF_DF_VALID_MASK     8'h7E
`define TSF_CFG3_VALID_MASK   8'h39
`define TSF_STATUS_RESET      8'h00
`endif

// ===== logic/tsf_pkg.sv
// types for the thermal status flag block
`default_nettype none
package tsf_pkg;
    typedef enum logic [3:0] {
        TSF_IDLE  = 4'b0000,
        TSF_ADDR  = 4'b0001,
        TSF_AACK  = 4'b0010,
        TSF_WDATA = 4'b0011,
        TSF_WACK  = 4'b0100,
        TSF_RDATA = 4'b0101,
        TSF_RACK  = 4'b0110,
        TSF_SKIP  = 4'b0111
    } tsf_state_t;
endpackage
`default_nettype wire

// ===== logic/tsf_status_flags.sv
// status flags, overtemperature output and two-wire slave of the temperature monitor
`timescale 1ns/1ps
`default_nettype none
`include "tsf_consts.svh"

// Summary of operation
// [RL1] channel 1 overtemperature sets status bit 0
// [RL2] channel 4 overtemperature sets status bit 3
// [RL3] channel 5 overtemperature sets status bit 4
// [RL4] channel 6 overtemperature sets status bit 5
// [RL5] diode faults channels 1-6 in bits 1-6
// [RL6] open or supply-tied anode flags diode fault
// [RL7] answer only at the fixed seven-bit address
// [RL8] faulted channels skipped by measurement sequence
// [RL9] masked channels never assert overtemperature output
// [RL10] flags zero at reset, reserved bits zero
module tsf_status_flags
    import tsf_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = `TSF_SLAVE_ADDR
) (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    input  wire logic [5:0] ch_over_limit_i,
    input  wire logic [5:0] diode_open_i,
    input  wire logic [5:0] anode_at_supply_i,
    input  wire logic       smb_clk_i,
    input  wire logic       smb_data_i,
    output logic            smb_data_oe_n_o,
    output logic            overtemp_output_oe_n_o,
    output logic [5:0]      ch_measure_en_o
);

    // status flags, bus engine state and registered output stages
    logic [7:0] overtemp_status_q;
    logic [7:0] diode_fault_status_q;
    logic [7:0] config3_q;
    logic [7:0] ptr_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic       rw_q;
    logic       first_q;
    tsf_state_t state_q;
    logic       scl_q;
    logic       sda_q;
    logic       sda_oe_n_q;
    logic       ot_oe_n_q;
    logic [5:0] meas_en_q;

    // flag inputs and the masked output term
    wire logic [7:0] ot_next;
    wire logic [7:0] df_next;
    wire logic       ot_assert;
    wire logic [7:0] rd_value;

    // the fault gate uses the registered flag: a channel that faults in the same cycle
    // may show one cycle of overtemp, traded for a short path from the fault pins
    assign ot_next[0] = ch_over_limit_i[0] & ~diode_fault_status_q[1]; // [RL1]
    assign ot_next[1] = 1'b0;
    assign ot_next[2] = 1'b0;

    // channels 4..6 share one form; bit n-1 is channel n
    genvar g;
    generate
        for (g = 3; g < 6; g++) begin : g_ot
            assign ot_next[g] = ch_over_limit_i[g] & ~diode_fault_status_q[g+1]; // [RL2] [RL3] [RL4]
        end
        for (g = 0; g < 6; g++) begin : g_df
            assign df_next[g+1] = diode_open_i[g] | anode_at_supply_i[g]; // [RL5] [RL6]
        end
    endgenerate
    assign ot_next[7:6] = 2'b00;    // [RL10]
    assign df_next[0]   = 1'b0;     // [RL10]
    assign df_next[7]   = 1'b0;     // [RL10]

    // a set flag on an unmasked bit pulls the open-drain output low
    assign ot_assert = |(overtemp_status_q & ~config3_q & `TSF_OT_VALID_MASK); // [RL9]

    // pointer decode; unmapped pointers read zero and drop writes
    wire logic ptr_is_ot  = (ptr_q == `TSF_REG_OVERTEMP);
    wire logic ptr_is_df  = (ptr_q == `TSF_REG_DIODE_FAULT);
    wire logic ptr_is_cfg = (ptr_q == `TSF_REG_CONFIG3);

    // register read selection
    assign rd_value = ptr_is_ot  ? overtemp_status_q :
                      ptr_is_df  ? diode_fault_status_q :
                      ptr_is_cfg ? config3_q : 8'h00;

    // flags follow the live condition; no sticky clear path, so a cleared cause drops its flag on the next clock
    // limitation: a host sees a flag only while its cause still stands
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            overtemp_status_q    <= `TSF_STATUS_RESET; // [RL10]
            diode_fault_status_q <= `TSF_STATUS_RESET; // [RL10]
            ot_oe_n_q            <= 1'b1;
            meas_en_q            <= 6'h00;
        end else begin
            overtemp_status_q    <= ot_next & `TSF_OT_VALID_MASK;
            diode_fault_status_q <= df_next & `TSF_DF_VALID_MASK;
            ot_oe_n_q            <= ~ot_assert;                 // [RL9]
            meas_en_q            <= ~diode_fault_status_q[6:1]; // [RL8]
        end
    end

    // one sample stage on the bus pins; they arrive in this clock domain already,
    // so the stage serves edge detection only; reset to the idle-high level
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= smb_clk_i;
            sda_q <= smb_data_i;
        end
    end

    // bus edge and condition detection: live pins against their registered copies
    wire logic scl_rise = smb_clk_i & ~scl_q;
    wire logic scl_fall = ~smb_clk_i & scl_q;
    wire logic start_c  = smb_clk_i & scl_q & sda_q & ~smb_data_i;
    wire logic stop_c   = smb_clk_i & scl_q & ~sda_q & smb_data_i;
    wire logic byte_in  = (bit_cnt_q == 4'h8);
    wire logic addr_hit = (shift_q[7:1] == SLAVE_ADDR); // [RL7]

    // byte-level slave: pointer write, config 3 write, register read
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state_q    <= TSF_IDLE;
            shift_q    <= 8'h00;
            bit_cnt_q  <= 4'h0;
            rw_q       <= 1'b0;
            first_q    <= 1'b0;
            ptr_q      <= 8'h00;
            config3_q  <= 8'h00;
            sda_oe_n_q <= 1'b1;
        end else begin
            // a start or stop wins over the byte state, so a host can always resync
            if (start_c) begin
                state_q    <= TSF_ADDR;
                bit_cnt_q  <= 4'h0;
                sda_oe_n_q <= 1'b1;
            end else if (stop_c) begin
                state_q    <= TSF_IDLE;
                sda_oe_n_q <= 1'b1;
            end else begin
                case (state_q)
                    TSF_ADDR, TSF_WDATA: begin
                        if (scl_rise && !byte_in) begin
                            shift_q   <= {shift_q[6:0], smb_data_i};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && byte_in) begin
                            bit_cnt_q <= 4'h0;
                            if (state_q == TSF_ADDR) begin
                                // foreign address: stay off the bus until the next start or stop
                                if (addr_hit) begin // [RL7]
                                    rw_q       <= shift_q[0];
                                    first_q    <= 1'b1;
                                    sda_oe_n_q <= 1'b0;
                                    state_q    <= TSF_AACK;
                                end else begin
                                    state_q <= TSF_SKIP;
                                end
                            end else begin
                                if (first_q) begin
                                    ptr_q <= shift_q;
                                end else if (ptr_is_cfg) begin
                                    config3_q <= shift_q & `TSF_CFG3_VALID_MASK;
                                end
                                first_q    <= 1'b0;
                                sda_oe_n_q <= 1'b0;
                                state_q    <= TSF_WACK;
                            end
                        end
                    end
                    TSF_AACK, TSF_WACK: begin
                        // the ack slot ends at the next clock fall; a read loads its byte there
                        if (scl_fall) begin
                            if (rw_q) begin
                                shift_q    <= {rd_value[6:0], 1'b0};
                                sda_oe_n_q <= rd_value[7];
                                bit_cnt_q  <= 4'h1;
                                state_q    <= TSF_RDATA;
                            end else begin
                                sda_oe_n_q <= 1'b1;
                                state_q    <= TSF_WDATA;
                            end
                        end
                    end
                    TSF_RDATA: begin
                        // bit 7 went out at the ack fall; seven more falls shift the rest
                        if (scl_fall) begin
                            if (byte_in) begin
                                sda_oe_n_q <= 1'b1;
                                state_q    <= TSF_RACK;
                            end else begin
                                sda_oe_n_q <= shift_q[7];
                                shift_q    <= {shift_q[6:0], 1'b0};
                                bit_cnt_q  <= bit_cnt_q + 4'h1;
                            end
                        end
                    end
                    TSF_RACK: begin
                        // master nack ends the read; ack repeats the same register
                        if (scl_rise) begin
                            state_q <= smb_data_i ? TSF_SKIP : TSF_AACK;
                        end
                    end
                    default: begin
                        // idle and skip wait for the next start
                        state_q <= state_q;
                    end
                endcase
            end
        end
    end

    // every pin comes straight from a flop; a low enable pulls the line down
    assign smb_data_oe_n_o        = sda_oe_n_q;
    assign overtemp_output_oe_n_o = ot_oe_n_q;
    assign ch_measure_en_o        = meas_en_q;

endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the thermal status flag block
`timescale 1ns/1ps
`default_nettype none
`include "tsf_consts.svh"
module tb_top;
    logic       clk_sys_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic [5:0] ov = 6'h00, op = 6'h00, sp = 6'h00, f, meas_en;
    logic       smb_clk, smb_data, data_oe_n, ot_oe_n, ok;
    logic [7:0] rd, m;
    // the other part variants' addresses, then this part's own address last
    logic [6:0] addr_tbl [4] = '{7'h1C, 7'h4D, 7'h4F, `TSF_SLAVE_ADDR};
    logic [31:0] r, corner [3] = '{32'hFC000020, 32'hFEA04019, 32'hFC000039};
    int         n_fail = 0, samples_checked = 0, seed = 32'hB21C4C9F;
    always #2 clk_sys_i = ~clk_sys_i;
    tsf_status_flags uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ch_over_limit_i(ov),
        .diode_open_i(op), .anode_at_supply_i(sp), .smb_clk_i(smb_clk), .smb_data_i(smb_data),
        .smb_data_oe_n_o(data_oe_n), .overtemp_output_oe_n_o(ot_oe_n), .ch_measure_en_o(meas_en));
    tsf_smb_host host (.clk_sys_i(clk_sys_i), .smb_data_oe_n_i(data_oe_n), .smb_clk_o(smb_clk),
        .smb_data_o(smb_data));
    // bit n-1 of each input is channel n; only channels 1, 4, 5, 6 carry overtemp bits
    function automatic logic [7:0] exp_ot(input logic [5:0] o, input logic [5:0] fl);
        return {2'b00, o & ~fl} & 8'h39;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // whole run is about 27k cycles; the limit of 75k cycles leaves nearly three times that
    initial begin
        #300000;
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        for (int p = 0; p < 3; p++) begin
            host.xact(`TSF_SLAVE_ADDR, 8'(p), 1'b0, 8'h00, rd, ok);
            chk(rd, 8'h00);
        end
        $display("test reset values done");
        // corner cases first: every channel hot, mixed faults and masks
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            r[25:14] = r[25:14] & 12'($random(seed)); // keep faults sparse
            if (i < 3) r = corner[i];
            ov <= r[31:26];
            op <= r[25:20];
            sp <= r[19:14];
            f = r[25:20] | r[19:14];
            m = r[7:0] & 8'h39;
            host.xact(`TSF_SLAVE_ADDR, `TSF_REG_CONFIG3, 1'b1, m, rd, ok);
            host.xact(`TSF_SLAVE_ADDR, `TSF_REG_CONFIG3, 1'b0, 8'h00, rd, ok);
            chk(rd, m);
            host.xact(`TSF_SLAVE_ADDR, `TSF_REG_OVERTEMP, 1'b0, 8'h00, rd, ok);
            chk(rd, exp_ot(r[31:26], f));
            host.xact(`TSF_SLAVE_ADDR, `TSF_REG_DIODE_FAULT, 1'b0, 8'h00, rd, ok);
            chk(rd, {1'b0, f, 1'b0});
            chk({7'h00, ok}, 8'h01);
            chk({2'b00, meas_en}, {2'b00, ~f});
            chk({7'h00, ot_oe_n}, {7'h00, ~|(exp_ot(r[31:26], f) & ~m)});
            $display("test %0d done", i);
        end
        // other variant addresses must be ignored; unmapped pointer reads zero
        for (int a = 0; a < 4; a++) begin
            host.xact(addr_tbl[a], 8'h05, 1'b0, 8'h00, rd, ok);
            chk({7'h00, ok}, {7'h00, a == 3});
        end
        chk(rd, 8'h00);
        $display("test addresses done");
        stop_test();
    end
endmodule
`default_nettype wire

// ===== tb/tsf_monitor.sv
// port assertions for the thermal status flag block
`timescale 1ns/1ps
`default_nettype none
module tsf_monitor (
    input wire logic       clk_sys_i,
    input wire logic       reset_n_i,
    input wire logic [5:0] ch_over_limit_i,
    input wire logic [5:0] diode_open_i,
    input wire logic [5:0] anode_at_supply_i,
    input wire logic       smb_clk_i,
    input wire logic       smb_data_oe_n_o,
    input wire logic       overtemp_output_oe_n_o,
    input wire logic [5:0] ch_measure_en_o
);
    // either fault cause counts, the flag does not say which
    wire logic [5:0] flt_w = diode_open_i | anode_at_supply_i;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // three edges out of reset, so both pipeline stages hold live data
    sequence s_up;
        reset_n_i [*3];
    endsequence
    out_reset_a:
    assert property (disable iff (1'b0) !reset_n_i |=> overtemp_output_oe_n_o && smb_data_oe_n_o
        && ch_measure_en_o == 6'h00) else $error("outputs not cleared by reset");
    start_quiet_a:
    assert property ($rose(reset_n_i) |-> overtemp_output_oe_n_o [*2]) else $error("early overtemp");
    ot_cause_a:
    assert property (!overtemp_output_oe_n_o |-> ($past(ch_over_limit_i, 2) & 6'h39
        & ~($past(flt_w, 2) & $past(flt_w, 3))) != 6'h00) else $error("overtemp without cause");
    meas_open_a:
    assert property (s_up |-> (ch_measure_en_o & $past(diode_open_i, 2)) == 6'h00)
        else $error("open channel still measured");
    meas_supply_a:
    assert property (s_up |-> (ch_measure_en_o & $past(anode_at_supply_i, 2)) == 6'h00)
        else $error("supply tied channel still measured");
    meas_good_a:
    assert property (s_up |-> (ch_measure_en_o | $past(flt_w, 2)) == 6'h3F) else $error("good channel dropped");
    data_edge_a:
    assert property ($past(reset_n_i) && $changed(smb_data_oe_n_o) |-> !smb_clk_i) else $error("data moved");
    bus_idle_a:
    assert property (smb_clk_i [*8] |-> smb_data_oe_n_o) else $error("data held on idle bus");
endmodule
bind tsf_status_flags tsf_monitor u_mon (
    .clk_sys_i              (clk_sys_i),
    .reset_n_i              (reset_n_i),
    .ch_over_limit_i        (ch_over_limit_i),
    .diode_open_i           (diode_open_i),
    .anode_at_supply_i      (anode_at_supply_i),
    .smb_clk_i              (smb_clk_i),
    .smb_data_oe_n_o        (smb_data_oe_n_o),
    .overtemp_output_oe_n_o (overtemp_output_oe_n_o),
    .ch_measure_en_o        (ch_measure_en_o)
);
`default_nettype wire

// ===== tb/tsf_smb_host.sv
// two-wire host model issuing register transactions
`timescale 1ns/1ps
`default_nettype none
module tsf_smb_host (
    input  wire logic clk_sys_i,
    input  wire logic smb_data_oe_n_i,
    output logic      smb_clk_o,
    output logic      smb_data_o
);
    localparam int H = 6; // half bit; only an idle bus keeps the clock high 8 cycles
    logic sda_low = 1'b0;
    initial smb_clk_o = 1'b1;
    // pulled-up line; an unknown slave enable before reset counts as released
    assign smb_data_o = !sda_low && (smb_data_oe_n_i !== 1'b0);
    task automatic hc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // data moves only while the clock is low, sampled at the end of the high phase
    task automatic bit_io(input logic b, output logic r);
        hc(1);
        sda_low <= !b;
        hc(H);
        smb_clk_o <= 1'b1;
        hc(H);
        r = smb_data_o;
        smb_clk_o <= 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]); // msb first
        bit_io(1'b1, a); // released: slave acks, or host nacks a read
    endtask
    // pointer phase, optional data byte, then a receive byte for reads
    task automatic xact(input logic [6:0] ad, input logic [7:0] p, input logic wr,
                        input logic [7:0] wd, output logic [7:0] rd, output logic ok);
        logic [7:0] q;
        logic       a0, a1, a2;
        a2 = 1'b0;
        rd = 8'hFF;
        for (int k = 0; k < 2; k++) begin
            if (k == 0 || !wr) begin
                sda_low <= 1'b1;
                hc(H);
                smb_clk_o <= 1'b0;
                byte_io({ad, k[0]}, q, a1);
                if (k == 0) a0 = a1;
                else a2 = a1;
                byte_io(k == 0 ? p : 8'hFF, rd, a1);
                if (k == 0 && wr) byte_io(wd, q, a1);
                if (k == 0) rd = 8'hFF;
                hc(1);
                sda_low <= 1'b1;
                hc(H);
                smb_clk_o <= 1'b1;
                hc(H);
                sda_low <= 1'b0;
                hc(2 * H);
            end
        end
        ok = !a0 && !a2;
    endtask
endmodule
`default_nettype wire
